// File: spmp_pkg.sv
// Functional notes
// - every message ends at its terminator
// - newline 8'h0a is the only terminator
// - short form from length and fourth vowel
// - accept exact short or long only
// - keyword compare ignores letter case
// - separator colon moves one level deeper
// - question mark after keyword makes query
// - data after last keyword is captured
// - semicolon closes unit, opens next
// - after semicolon resolve at previous level
// - leading colon returns path to root
// - terminator returns path to root
// - first unit of message starts at root
// - omitted source acts as if supplied
// - voltage current function accepted at root
// - root accepts the eleven subsystem keywords
// - asterisk unit is a common command
package spmp_pkg;

  // ************************************************
  // sizes and characters
  // ************************************************
  localparam int         PATH_DEPTH = 4;     // keyword levels held
  localparam int         PARAM_LEN  = 16;    // data characters held
  localparam int         KW_MAX     = 12;    // longest keyword
  localparam int         KW_NUM     = 25;    // table entries
  localparam int         FIFO_DEPTH = 4;     // input buffer words
  localparam logic [7:0] CH_NL      = 8'h0a; // terminator
  localparam logic [7:0] CH_SPACE   = 8'h20;
  localparam logic [7:0] CH_STAR    = 8'h2a;
  localparam logic [7:0] CH_COLON   = 8'h3a;
  localparam logic [7:0] CH_SEMI    = 8'h3b;
  localparam logic [7:0] CH_QMARK   = 8'h3f;
  localparam logic [7:0] CH_UC_A    = 8'h41;
  localparam logic [7:0] CH_UC_Z    = 8'h5a;
  localparam logic [7:0] CH_LC_A    = 8'h61;
  localparam logic [7:0] CH_LC_Z    = 8'h7a;
  localparam logic [7:0] CASE_BIT   = 8'h20;
  localparam logic [3:0] SHORT_FULL = 4'h4;  // longest all-letter short
  localparam logic [3:0] SHORT_VOW  = 4'h3;  // short when fourth vowel
  localparam logic [4:0] KW_SOURCE  = 5'h07; // optional root keyword

  // ************************************************
  // types
  // ************************************************
  typedef logic [4:0] spmp_kw_t;
  typedef enum logic [2:0] {
    S_START, S_SEP, S_KEY, S_QRY, S_PARAM, S_CMN, S_SKIP
  } spmp_state_e;

  // keyword entry: right-justified text, length, level flags
  typedef struct packed {
    logic [8*KW_MAX-1:0] txt;
    logic [3:0]          len;
    logic                root;
    logic                src;
  } spmp_kw_s;

  // one finished message unit
  typedef struct packed {
    logic                        common;
    logic                        query;
    logic [2:0]                  depth;
    spmp_kw_t [PATH_DEPTH-1:0]   path;
    logic [PARAM_LEN-1:0][7:0]   param;
    logic [4:0]                  plen;
  } spmp_unit_s;

  // whole parser state
  typedef struct packed {
    spmp_state_e                 st;
    logic [KW_MAX-1:0][7:0]      kbuf;
    logic [3:0]                  klen;
    logic [2:0]                  lvl;
    logic [2:0]                  kpos;
    spmp_kw_t [PATH_DEPTH-1:0]   path;
    logic                        query;
    logic                        common;
    logic [PARAM_LEN-1:0][7:0]   pbuf;
    logic [4:0]                  plen;
    spmp_unit_s                  unit;
    logic                        uval;
    logic                        err;
  } spmp_prs_s;

  localparam spmp_prs_s PRS_RST = '0;

  // keyword table; root flag marks root-level names
  localparam spmp_kw_s KW_TABLE [KW_NUM] = '{
    '{96'("ABORT"),        4'h5, 1'b1, 1'b0},
    '{96'("CALIBRATE"),    4'h9, 1'b1, 1'b0},
    '{96'("DISPLAY"),      4'h7, 1'b1, 1'b0},
    '{96'("INITIATE"),     4'h8, 1'b1, 1'b0},
    '{96'("LIST"),         4'h4, 1'b1, 1'b0},
    '{96'("MEASURE"),      4'h7, 1'b1, 1'b0},
    '{96'("OUTPUT"),       4'h6, 1'b1, 1'b0},
    '{96'("SOURCE"),       4'h6, 1'b1, 1'b0},
    '{96'("STATUS"),       4'h6, 1'b1, 1'b0},
    '{96'("SYSTEM"),       4'h6, 1'b1, 1'b0},
    '{96'("TRIGGER"),      4'h7, 1'b1, 1'b0},
    '{96'("VOLTAGE"),      4'h7, 1'b0, 1'b1},
    '{96'("CURRENT"),      4'h7, 1'b0, 1'b1},
    '{96'("FUNCTION"),     4'h8, 1'b0, 1'b1},
    '{96'("LEVEL"),        4'h5, 1'b0, 1'b0},
    '{96'("IMMEDIATE"),    4'h9, 1'b0, 1'b0},
    '{96'("OPERATION"),    4'h9, 1'b0, 1'b0},
    '{96'("PRESET"),       4'h6, 1'b0, 1'b0},
    '{96'("QUESTIONABLE"), 4'hc, 1'b0, 1'b0},
    '{96'("CONDITION"),    4'h9, 1'b0, 1'b0},
    '{96'("ENABLE"),       4'h6, 1'b0, 1'b0},
    '{96'("EVENT"),        4'h5, 1'b0, 1'b0},
    '{96'("ERROR"),        4'h5, 1'b0, 1'b0},
    '{96'("STATE"),        4'h5, 1'b0, 1'b0},
    '{96'("MODE"),         4'h4, 1'b0, 1'b0}
  };

  // ************************************************
  // helpers
  // ************************************************
  // fold lower case letters to upper case
  function automatic logic [7:0] to_upper(logic [7:0] c);
    if (c >= CH_LC_A && c <= CH_LC_Z) begin
      return c - CASE_BIT;
    end
    return c;
  endfunction

  function automatic logic is_letter(logic [7:0] c);
    return c >= CH_UC_A && c <= CH_UC_Z;
  endfunction

  // character i from the left of a table entry
  function automatic logic [7:0] kw_char(spmp_kw_s k, int i);
    if (i >= int'(k.len)) begin
      return 8'h00;
    end
    return k.txt[8*(int'(k.len)-1-i) +: 8];
  endfunction

  // short form length of a table entry
  function automatic logic [3:0] short_len(spmp_kw_s k);
    logic [7:0] c4;
    c4 = kw_char(k, 3);
    if (k.len <= SHORT_FULL) begin
      return k.len;
    end
    if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U") begin
      return SHORT_VOW;
    end
    return SHORT_FULL;
  endfunction

endpackage

// File: spmp_fifo.sv
module spmp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  logic         i_clk,
  input  logic         i_sys_rst,
  input  logic         i_valid,
  input  logic [W-1:0] i_data,
  output logic         o_ready,
  output logic         o_valid,
  output logic [W-1:0] o_data,
  input  logic         i_ready
);
  import spmp_pkg::*;

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [D-1:0][W-1:0] mem; // storage words
    logic [AW-1:0]       wp;  // write pointer
    logic [AW-1:0]       rp;  // read pointer
    logic [AW:0]         cnt; // words held
    logic                rdy; // room for one more
  } spmp_fifo_s;

  spmp_fifo_s r;
  spmp_fifo_s n;
  logic       push;
  logic       pop;

  assign o_ready = r.rdy;
  assign o_valid = r.cnt != '0;
  assign o_data  = r.mem[r.rp];
  assign push    = i_valid && r.rdy;
  assign pop     = o_valid && i_ready;

  // next state: store, drain, count
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = i_data;
      n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
    n.rdy = n.cnt != FULL;
  end

  // register; ready comes up one edge after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

// File: spmp_kw_match.sv
module spmp_kw_match (
  input  logic [spmp_pkg::KW_MAX-1:0][7:0] i_kbuf,
  input  logic [3:0]                       i_klen,
  input  logic                             i_root,
  output logic                             o_hit,
  output spmp_pkg::spmp_kw_t               o_idx
);
  import spmp_pkg::*;

  logic [KW_NUM-1:0] hit_w; // one bit per table entry

  // all typed letters equal the entry's leading letters;
  // buffer and length come in as arguments so the compare follows them
  function automatic logic same(spmp_kw_s k, logic [KW_MAX-1:0][7:0] b, logic [3:0] l);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < KW_MAX; i++) begin
      if (i < int'(l) && b[i] != kw_char(k, i)) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ************************************************
  // per-entry compare
  // ************************************************
  for (genvar e = 0; e < KW_NUM; e++) begin : g_kw
    // exact short or long length only
    assign hit_w[e] = same(KW_TABLE[e], i_kbuf, i_klen)
                      && (i_klen == short_len(KW_TABLE[e])
                          || i_klen == KW_TABLE[e].len)
                      && (!i_root || KW_TABLE[e].root
                          || KW_TABLE[e].src);
  end

  // lowest matching entry wins
  always_comb begin
    o_hit = |hit_w;
    o_idx = '0;
    for (int e = KW_NUM - 1; e >= 0; e--) begin
      if (hit_w[e]) begin
        o_idx = spmp_kw_t'(e);
      end
    end
  end

endmodule

// File: spmp_parser.sv
module spmp_parser #(
  parameter int FIFO_D = spmp_pkg::FIFO_DEPTH
) (
  input  logic                 i_clk,
  input  logic                 i_sys_rst,
  input  logic                 i_char_valid,
  input  logic [7:0]           i_char,
  output logic                 o_char_ready,
  input  logic                 i_exec_busy,
  input  logic                 i_err_clr,
  output logic                 o_unit_valid,
  output spmp_pkg::spmp_unit_s o_unit,
  output logic                 o_err
);
  import spmp_pkg::*;

  localparam logic [2:0] LVL_MAX = 3'(PATH_DEPTH);
  localparam logic [3:0] KLEN_MAX = 4'(KW_MAX);
  localparam logic [4:0] PLEN_MAX = 5'(PARAM_LEN);

  // ************************************************
  // declarations
  // ************************************************
  spmp_prs_s  r;        // registered state
  spmp_prs_s  n;        // next state
  logic       c_valid;  // buffered character present
  logic [7:0] c_data;   // buffered character
  logic       c_take;   // parser consumes this cycle
  logic       kw_hit;   // keyword buffer is valid here
  spmp_kw_t   kw_idx;   // matched table entry
  logic [7:0] u;        // upper-case view of character
  logic       do_place; // resolve the keyword now
  logic       do_emit;  // close the unit now
  logic       do_err;   // syntax or keyword error
  logic       is_delim; // character ends a keyword
  logic       is_end;   // semicolon or terminator

  // ************************************************
  // input buffer
  // ************************************************
  // executing logic may hold the parser off
  assign c_take = !i_exec_busy;

  spmp_fifo #(
    .W (8),
    .D (FIFO_D)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_valid   (i_char_valid),
    .i_data    (i_char),
    .o_ready   (o_char_ready),
    .o_valid   (c_valid),
    .o_data    (c_data),
    .i_ready   (c_take)
  );

  // ************************************************
  // keyword lookup
  // ************************************************
  // root-only names apply while at level zero
  spmp_kw_match u_match (
    .i_kbuf (r.kbuf),
    .i_klen (r.klen),
    .i_root (r.lvl == '0),
    .o_hit  (kw_hit),
    .o_idx  (kw_idx)
  );

  // ************************************************
  // character classes
  // ************************************************
  assign u        = to_upper(c_data);
  assign is_end   = (u == CH_SEMI) || (u == CH_NL);
  assign is_delim = is_end || (u == CH_COLON)
                    || (u == CH_QMARK) || (u == CH_SPACE);

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb begin
    n        = r;
    n.uval   = 1'b0;
    do_place = 1'b0;
    do_emit  = 1'b0;
    do_err   = 1'b0;
    // clear first so a new error in this cycle wins
    if (i_err_clr) begin
      n.err = 1'b0;
    end
    if (c_valid && c_take) begin
      unique case (r.st)
        // start of a unit
        S_START: begin
          if (u == CH_SPACE) begin
            // blanks after a semicolon are skipped
          end else if (u == CH_COLON) begin
            n.lvl = '0;
            n.st  = S_SEP;
          end else if (u == CH_STAR) begin
            n.common = 1'b1;
            n.st     = S_CMN;
          end else if (is_letter(u)) begin
            n.kbuf    = '0;
            n.kbuf[0] = u;
            n.klen    = 4'h1;
            n.st      = S_KEY;
          end else if (u == CH_NL) begin
            // empty trailing unit: just end the message
            n.lvl = '0;
          end else begin
            do_err = 1'b1;
          end
        end
        // after a colon a keyword must follow
        S_SEP: begin
          if (is_letter(u)) begin
            n.kbuf    = '0;
            n.kbuf[0] = u;
            n.klen    = 4'h1;
            n.st      = S_KEY;
          end else begin
            do_err = 1'b1;
          end
        end
        // collecting keyword letters
        S_KEY: begin
          if (is_letter(u)) begin
            if (r.klen == KLEN_MAX) begin
              do_err = 1'b1;
            end else begin
              n.kbuf[r.klen] = u;
              n.klen         = r.klen + 4'h1;
            end
          end else if (is_delim) begin
            do_place = 1'b1;
          end else begin
            do_err = 1'b1;
          end
        end
        // after the query mark
        S_QRY: begin
          if (u == CH_SPACE) begin
            n.st = S_PARAM;
          end else if (is_end) begin
            do_emit = 1'b1;
          end else begin
            do_err = 1'b1;
          end
        end
        // collecting the data field
        S_PARAM: begin
          if (is_end) begin
            do_emit = 1'b1;
          end else if (u == CH_SPACE && r.plen == '0) begin
            // leading blanks are not data
          end else if (r.plen == PLEN_MAX) begin
            do_err = 1'b1;
          end else begin
            n.pbuf[r.plen[3:0]] = c_data;
            n.plen              = r.plen + 5'h01;
          end
        end
        // common command name and argument
        S_CMN: begin
          if (is_end) begin
            do_emit = 1'b1;
          end else if (u == CH_QMARK) begin
            n.query = 1'b1;
          end else if (r.plen == PLEN_MAX) begin
            do_err = 1'b1;
          end else begin
            n.pbuf[r.plen[3:0]] = u;
            n.plen              = r.plen + 5'h01;
          end
        end
        // discarding the rest of a bad message
        S_SKIP: begin
          if (u == CH_NL) begin
            n.st  = S_START;
            n.lvl = '0;
          end
        end
      endcase
    end

    // resolve keyword into the path
    if (do_place) begin
      if (!kw_hit || r.lvl >= LVL_MAX) begin
        do_err = 1'b1;
      end else if (r.lvl == '0 && KW_TABLE[kw_idx].src) begin
        // implied source keyword is filled in
        n.path[0] = KW_SOURCE;
        n.path[1] = kw_idx;
        n.kpos    = 3'h1;
      end else begin
        for (int k = 0; k < PATH_DEPTH; k++) begin
          if (3'(k) == r.lvl) begin
            n.path[k] = kw_idx;
          end
        end
        n.kpos = r.lvl;
      end
      if (!do_err) begin
        n.klen = '0;
        if (u == CH_COLON) begin
          n.lvl = n.kpos + 3'h1;
          n.st  = S_SEP;
        end else if (u == CH_QMARK) begin
          n.query = 1'b1;
          n.st    = S_QRY;
        end else if (u == CH_SPACE) begin
          n.st = S_PARAM;
        end else begin
          do_emit = 1'b1;
        end
      end
    end

    // hand the finished unit to the executing logic
    if (do_emit && !do_err) begin
      n.unit.common = n.common;
      n.unit.query  = n.query;
      n.unit.depth  = n.common ? 3'h0 : n.kpos + 3'h1;
      n.unit.path   = n.path;
      n.unit.param  = n.pbuf;
      n.unit.plen   = n.plen;
      n.uval        = 1'b1;
      n.st          = S_START;
      if (u == CH_NL) begin
        // message over; next one starts at root
        n.lvl = '0;
      end else if (!n.common) begin
        // sibling of the last keyword
        n.lvl = n.kpos;
      end
    end

    // clear per-unit fields after a unit closes
    if (do_emit || do_err) begin
      n.query  = 1'b0;
      n.common = 1'b0;
      n.pbuf   = '0;
      n.plen   = '0;
      n.klen   = '0;
    end

    // sticky error; skip to the terminator
    if (do_err) begin
      n.err = 1'b1;
      if (u == CH_NL) begin
        n.st  = S_START;
        n.lvl = '0;
      end else begin
        n.st = S_SKIP;
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      r <= PRS_RST;
    end else begin
      r <= n;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign o_unit_valid = r.uval;
  assign o_unit       = r.unit;
  assign o_err        = r.err;

endmodule

// File: spmp_parser_checker.sv
// ****************************************
// port checker for the message parser
// ****************************************
module spmp_parser_checker #(
  parameter int FIFO_D = 4
) (
  input logic                 i_clk,
  input logic                 i_sys_rst,
  input logic                 i_char_valid,
  input logic [7:0]           i_char,
  input logic                 o_char_ready,
  input logic                 i_exec_busy,
  input logic                 i_err_clr,
  input logic                 o_unit_valid,
  input spmp_pkg::spmp_unit_s o_unit,
  input logic                 o_err
);
  import spmp_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // reset clears every output one edge later
  property p_rst_quiet;
    disable iff (1'b0) i_sys_rst |=> !o_unit_valid && !o_err && !o_char_ready;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not quiet after reset");
  // error flag holds until cleared
  property p_err_sticky;
    o_err && !i_err_clr |=> o_err;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped without clear");
  // a bad unit is never announced
  property p_err_alone;
    $rose(o_err) |-> !o_unit_valid;
  endproperty
  a_err_alone: assert property (p_err_alone)
    else $error("unit pulse with fresh error");
  // unit output only moves with its pulse
  property p_unit_hold;
    $changed(o_unit) |-> o_unit_valid;
  endproperty
  a_unit_hold: assert property (p_unit_hold)
    else $error("unit changed without pulse");
  // common commands sit outside the tree
  property p_common_flat;
    o_unit_valid && o_unit.common |-> o_unit.depth == 3'h0;
  endproperty
  a_common_flat: assert property (p_common_flat)
    else $error("common unit with tree depth");
  // tree units hold one to four levels
  property p_tree_depth;
    o_unit_valid && !o_unit.common |-> o_unit.depth inside {[3'h1:3'h4]};
  endproperty
  a_tree_depth: assert property (p_tree_depth)
    else $error("tree depth out of range");
  // first level is always a root keyword
  property p_root_first;
    o_unit_valid && !o_unit.common |-> o_unit.path[0] <= 5'h0a;
  endproperty
  a_root_first: assert property (p_root_first)
    else $error("first level not a root keyword");
  // captured data never exceeds its store
  property p_plen_max;
    o_unit_valid |-> o_unit.plen <= 5'h10;
  endproperty
  a_plen_max: assert property (p_plen_max)
    else $error("parameter length too large");
  // four takes while stalled fill the buffer
  property p_fill;
    (i_char_valid && o_char_ready && i_exec_busy) [*4] |=> !o_char_ready;
  endproperty
  a_fill: assert property (p_fill)
    else $error("buffer accepts beyond its depth");

  c_query: cover property (o_unit_valid && o_unit.query);
  c_common: cover property (o_unit_valid && o_unit.common);
  c_err: cover property ($rose(o_err));
endmodule

bind spmp_parser spmp_parser_checker #(.FIFO_D(FIFO_D)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_char_valid(i_char_valid), .i_char(i_char),
  .o_char_ready(o_char_ready), .i_exec_busy(i_exec_busy), .i_err_clr(i_err_clr),
  .o_unit_valid(o_unit_valid), .o_unit(o_unit), .o_err(o_err));

// File: spmp_host_model.sv
// ****************************************
// remote controller sending characters
// ****************************************
module spmp_host_model (
  input  logic       i_clk,
  input  logic       i_ready,
  output logic       o_valid,
  output logic [7:0] o_char
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_char  = 8'h00;
  end
  // send text; each char held until taken, gap idles between chars
  task automatic send(input string s, input int gap);
    int i;
    @(negedge i_clk);
    for (i = 0; i < s.len(); i++) begin
      o_valid = 1'b1;
      o_char  = s[i];
      // ready is settled at the falling edge; the next rising edge takes the char
      while (i_ready !== 1'b1) begin
        @(negedge i_clk);
      end
      @(negedge i_clk);
      // idle data toggles so a stale value is never mistaken
      repeat (gap) begin
        o_valid = 1'b0;
        o_char  = ~o_char;
        @(negedge i_clk);
      end
    end
    o_valid = 1'b0;
    o_char  = ~o_char;
  endtask
endmodule

// File: spmp_parser_tb.sv
module spmp_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spmp_pkg::*;
  logic       i_clk;
  logic       i_sys_rst;
  logic       i_char_valid;
  logic [7:0] i_char;
  logic       o_char_ready;
  logic       i_exec_busy;
  logic       i_err_clr;
  logic       o_unit_valid;
  spmp_unit_s o_unit;
  logic       o_err;
  spmp_unit_s units[$]; // announced units
  int         errors;
  int         num_checks;
  int         cycles;

  spmp_parser #(.FIFO_D(FIFO_DEPTH)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_char_valid(i_char_valid), .i_char(i_char),
    .o_char_ready(o_char_ready), .i_exec_busy(i_exec_busy), .i_err_clr(i_err_clr),
    .o_unit_valid(o_unit_valid), .o_unit(o_unit), .o_err(o_err));
  spmp_host_model u_host (.i_clk(i_clk), .i_ready(o_char_ready), .o_valid(i_char_valid), .o_char(i_char));

  // ****************************************
  // clock, monitor and timeout
  // ****************************************
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  // collect each pulsed unit, sampled where it is settled
  always @(negedge i_clk) begin
    if (o_unit_valid === 1'b1) begin
      units.push_back(o_unit);
    end
  end
  // cut a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("Error at %0t: run timed out", $time);
      print_verdict();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // send a message and let its units land
  task automatic msg(input string s, input int gap);
    u_host.send(s, gap);
    repeat (4) @(posedge i_clk);
  endtask
  // pop one unit and compare its fields, path only up to the third level
  task automatic exp_unit(input logic q, input logic cm, input int d, input int p0, input int p1,
                          input int p2, input string prm);
    spmp_unit_s u;
    int         pe[3];
    int         i;
    pe = '{p0, p1, p2};
    if (units.size() == 0) begin
      check(32'h0, 32'h1);
      return;
    end
    u = units.pop_front();
    check(32'(u.common), 32'(cm));
    check(32'(u.query), 32'(q));
    check(32'(u.depth), d);
    for (i = 0; i < d && i < 3; i++) begin
      check(32'(u.path[i]), pe[i]);
    end
    check(32'(u.plen), prm.len());
    for (i = 0; i < prm.len(); i++) begin
      check(32'(u.param[i]), 32'(prm[i]));
    end
  endtask
  task automatic clr_err();
    @(negedge i_clk);
    i_err_clr = 1'b1;
    @(negedge i_clk);
    i_err_clr = 1'b0;
    check(32'(o_err), 32'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic();
    msg("VOLT 5\n", 0);
    exp_unit(0, 0, 2, KW_SOURCE, 11, 0, "5");
    msg("VOLT 5\015\n", 0);
    exp_unit(0, 0, 2, 7, 11, 0, "5\015");
    check(units.size(), 0);
    $display("test basic done");
  endtask
  task automatic t_tree();
    msg("meas:volt?;curr?\n", 0);
    exp_unit(1, 0, 2, 5, 11, 0, "");
    exp_unit(1, 0, 2, 5, 12, 0, "");
    msg("meas:volt?;:curr?\n", 0);
    exp_unit(1, 0, 2, 5, 11, 0, "");
    exp_unit(1, 0, 2, 7, 12, 0, "");
    msg("STAT:OPER:COND?;ENAB 16\n", 0);
    exp_unit(1, 0, 3, 8, 16, 19, "");
    exp_unit(0, 0, 3, 8, 16, 20, "16");
    $display("test tree done");
  endtask
  task automatic t_forms();
    msg("ouTPut ON;OUTP OFF\n", 0);
    exp_unit(0, 0, 1, 6, 0, 0, "ON");
    exp_unit(0, 0, 1, 6, 0, 0, "OFF");
    msg("VOLT:lev 3\n", 0);
    exp_unit(0, 0, 3, 7, 11, 14, "3");
    msg("SOUR:VOLT:LEVEL 4\n", 0);
    exp_unit(0, 0, 3, 7, 11, 14, "4");
    $display("test forms done");
  endtask
  // every root keyword in short form, each from the root
  task automatic t_root();
    int i;
    msg("ABOR;:CAL;:DISP;:INIT;:LIST;:MEAS;:OUTP;:SOUR;:STAT;:SYST;:TRIG\n", 0);
    for (i = 0; i < 11; i++) begin
      exp_unit(0, 0, 1, i, 0, 0, "");
    end
    $display("test root done");
  endtask
  task automatic t_reject();
    string bad[5];
    int    i;
    bad = '{"IMME\n", "STAT:OPER:ENABL 1\n", "VOLT:LEVE 3\n", "VOLTA 2\n", "LEV 3\n"};
    for (i = 0; i < 5; i++) begin
      msg(bad[i], 0);
      check(32'(o_err), 32'h1);
      check(units.size(), 0);
      clr_err();
    end
    $display("test reject done");
  endtask
  task automatic t_skip();
    msg("VOLT:LEVE 3;CURR 1\nCURR 2\n", 0);
    check(32'(o_err), 32'h1);
    exp_unit(0, 0, 2, 7, 12, 0, "2");
    check(units.size(), 0);
    clr_err();
    msg("MEAS:VOLT?\n", 2);
    msg("CURR?\n", 2);
    exp_unit(1, 0, 2, 5, 11, 0, "");
    exp_unit(1, 0, 2, 7, 12, 0, "");
    $display("test skip done");
  endtask
  task automatic t_common();
    msg("*idn?;*RST\n", 0);
    exp_unit(1, 1, 0, 0, 0, 0, "IDN");
    exp_unit(0, 1, 0, 0, 0, 0, "RST");
    msg("MEAS:VOLT?;*CLS;CURR?\n", 0);
    exp_unit(1, 0, 2, 5, 11, 0, "");
    exp_unit(0, 1, 0, 0, 0, 0, "CLS");
    exp_unit(1, 0, 2, 5, 12, 0, "");
    $display("test common done");
  endtask
  // stall the executor until the buffer refuses, then drain
  task automatic t_fill();
    @(negedge i_clk);
    i_exec_busy = 1'b1;
    fork
      u_host.send("VOLT 7\n", 0);
    join_none
    repeat (8) @(negedge i_clk);
    check(32'(o_char_ready), 32'h0);
    check(units.size(), 0);
    i_exec_busy = 1'b0;
    wait fork;
    repeat (10) @(posedge i_clk);
    exp_unit(0, 0, 2, 7, 11, 0, "7");
    check(32'(o_char_ready), 32'h1);
    $display("test fill done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    i_sys_rst   = 1'b1;
    i_exec_busy = 1'b0;
    i_err_clr   = 1'b0;
    errors      = 0;
    num_checks  = 0;
    cycles      = 0;
    repeat (12) @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    check(32'(o_err), 32'h0);
    check(32'(o_char_ready), 32'h1);
    t_basic();
    t_tree();
    t_forms();
    t_root();
    t_reject();
    t_skip();
    t_common();
    t_fill();
    print_verdict();
  end
endmodule
